// ---- core/pmt_pkg.sv ----
`default_nettype none
package pmt_pkg;
  // register map: offsets are our own choice, one byte wide each
  localparam logic [1:0] OFF_COUNT   = 2'h0;
  localparam logic [1:0] OFF_PERIOD  = 2'h1;
  localparam logic [1:0] OFF_CONTROL = 2'h2;
  localparam logic [1:0] OFF_FLAG    = 2'h3;
  // reset values
  localparam logic [7:0] COUNT_RST   = 8'h00;
  localparam logic [7:0] PERIOD_RST  = 8'hff;
  localparam logic [6:0] CONTROL_RST = 7'h00;
  // control field positions
  localparam int POST_LSB  = 3;
  localparam int POST_MSB  = 6;
  localparam int RUN_BIT   = 2;
  localparam int PRE_LSB   = 0;
  localparam int PRE_MSB   = 1;
  // flag register: match flag position
  localparam int FLAG_BIT  = 1;
  // prescale select encodings
  typedef enum logic [1:0] {
    PMT_DIV1  = 2'h0,
    PMT_DIV4  = 2'h1,
    PMT_DIV16 = 2'h2,
    PMT_DIV64 = 2'h3
  } pmt_pre_t;
endpackage : pmt_pkg
`default_nettype wire

// ---- core/pmt_timer.sv ----
// How it works
// - counts the instruction clock through prescaler
// - prescaler ratios 1, 4, 16, 64
// - prescale ratio from control prescale_select field
// - each prescaler pulse increments count while running, except in a cycle that writes count or control
// - count rises from zero, compared with period
// - after match, next increment returns count to zero
// - each match advances postscaler counter
// - postscaler ratios 1 through 16
// - postscaler output sets match_flag
// - count and period readable and writable anytime
// - reset loads count zero, period all ones
// - counts only while timer_run is one
// - postscale ratio from control postscale_select field
// - count write clears prescaler and postscaler
// - control write clears prescaler and postscaler
// - every reset clears prescaler and postscaler
// - control write leaves count unchanged
`timescale 1ns/100ps
`default_nettype none
module pmt_timer #(
  parameter int PRE_W = 6
) (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [1:0] addr,
  input  wire logic [7:0] wrData,
  input  wire logic       wrStb,
  input  wire logic       rdStb,
  output logic      [7:0] rdData,
  output logic            matchFlag,
  output logic            timerRun
);
  import pmt_pkg::*;

  // notes for the next engineer:
  // - clk is taken as the instruction clock itself, so one tick is one cycle
  // - the prescaler free-runs only while the timer runs, which saves toggling
  // - a match is counted on the wrap increment, not on the compare edge, so
  //   the postscaler and the flag step one tick after the count equals period
  // - a software write to count or control swallows the tick of that cycle;
  //   this keeps the write value exact at the cost of one lost increment
  // - period zero makes every tick a wrap, the fastest flag rate

  // the prescaler must reach the 1:64 tap
  if (PRE_W < 6) begin : g_pre_w_check
    $error("PRE_W too small for 1:64 prescale");
  end

  logic [7:0]       count_r;
  logic [7:0]       period_r;
  logic [6:0]       control_r;
  logic [PRE_W-1:0] pre_r;
  logic [3:0]       post_r;
  logic             flag_r;
  logic [7:0]       rdData_r;

  logic wrCount;
  logic wrPeriod;
  logic wrControl;
  logic wrFlag;
  logic preTick;
  logic match;
  logic incr;
  logic postOut;
  logic [1:0] preSel;
  logic [3:0] postSel;

  // write decode
  assign wrCount   = wrStb && (addr == OFF_COUNT);
  assign wrPeriod  = wrStb && (addr == OFF_PERIOD);
  assign wrControl = wrStb && (addr == OFF_CONTROL);
  assign wrFlag    = wrStb && (addr == OFF_FLAG);

  assign preSel  = control_r[PRE_MSB:PRE_LSB];
  assign postSel = control_r[POST_MSB:POST_LSB];
  assign timerRun = control_r[RUN_BIT];

  // prescaler terminal count per selected ratio
  always_comb begin
    case (pmt_pre_t'(preSel))
      PMT_DIV1:  preTick = 1'b1;
      PMT_DIV4:  preTick = (pre_r[1:0] == 2'h3);
      PMT_DIV16: preTick = (pre_r[3:0] == 4'hf);
      PMT_DIV64: preTick = (pre_r[5:0] == 6'h3f);
      default:   preTick = 1'b0;
    endcase
  end

  // clk stands in for the quarter-oscillator instruction clock
  assign incr  = timerRun && preTick && !wrCount && !wrControl;
  assign match = (count_r == period_r);
  // a match produces one postscaler step when the count wraps
  assign postOut = incr && match && (post_r == postSel);

  // prescaler counter; stalls with the timer off
  always_ff @(posedge clk) begin
    if (!nrst) begin
      pre_r <= '0;
    end else if (wrCount || wrControl) begin
      pre_r <= '0;
    end else if (timerRun) begin
      pre_r <= pre_r + 1'b1;
    end
  end

  // count register; a control write does not touch it
  always_ff @(posedge clk) begin
    if (!nrst) begin
      count_r <= COUNT_RST;
    end else if (wrCount) begin
      count_r <= wrData;
    end else if (incr) begin
      count_r <= match ? COUNT_RST : count_r + 8'h01;
    end
  end

  // period register
  always_ff @(posedge clk) begin
    if (!nrst) begin
      period_r <= PERIOD_RST;
    end else if (wrPeriod) begin
      period_r <= wrData;
    end
  end

  // control register; bit 7 is not stored
  always_ff @(posedge clk) begin
    if (!nrst) begin
      control_r <= CONTROL_RST;
    end else if (wrControl) begin
      control_r <= wrData[6:0];
    end
  end

  // postscaler counter: counts matches, wraps at the selected ratio
  always_ff @(posedge clk) begin
    if (!nrst) begin
      post_r <= 4'h0;
    end else if (wrCount || wrControl) begin
      post_r <= 4'h0;
    end else if (incr && match) begin
      post_r <= (post_r == postSel) ? 4'h0 : post_r + 4'h1;
    end
  end

  // match flag: the hardware set beats a software clear in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else if (postOut) begin
      flag_r <= 1'b1;
    end else if (wrFlag && !wrData[FLAG_BIT]) begin
      flag_r <= 1'b0;
    end
  end
  assign matchFlag = flag_r;

  // read data stands one cycle after the strobe only
  always_ff @(posedge clk) begin
    if (!nrst) begin
      rdData_r <= 8'h00;
    end else if (rdStb) begin
      case (addr)
        OFF_COUNT:   rdData_r <= count_r;
        OFF_PERIOD:  rdData_r <= period_r;
        OFF_CONTROL: rdData_r <= {1'b0, control_r};
        OFF_FLAG:    rdData_r <= {6'h00, flag_r, 1'b0};
        default:     rdData_r <= 8'h00;
      endcase
    end else begin
      rdData_r <= 8'h00;
    end
  end
  assign rdData = rdData_r;

  // checks below watch only what this block drives; all run on clk and are
  // quiet while nrst is low, except the reset value checks

  // a matched count wraps to zero on the next increment
  chk_wrap_zero: assert property (@(posedge clk) disable iff (!nrst)
    incr && match && !wrCount |=> count_r == 8'h00)
    else $error("count did not wrap after match");

  // a stopped timer holds its count
  chk_run_hold: assert property (@(posedge clk) disable iff (!nrst)
    !timerRun && !wrCount |=> $stable(count_r))
    else $error("count moved while stopped");

  // control write clears both scaler counters and keeps count
  chk_ctl_clear: assert property (@(posedge clk) disable iff (!nrst)
    wrControl |=> pre_r == '0 && post_r == 4'h0 && $stable(count_r))
    else $error("control write effects wrong");

  // count write clears scalers and loads data
  chk_cnt_write: assert property (@(posedge clk) disable iff (!nrst)
    wrCount |=> pre_r == '0 && post_r == 4'h0 && count_r == $past(wrData))
    else $error("count write effects wrong");

  // running at 1:1 the count steps every cycle below the period
  chk_pre_one: assert property (@(posedge clk) disable iff (!nrst)
    timerRun && preSel == 2'h0 && !match && !wrStb |=> count_r == $past(count_r) + 8'h01)
    else $error("1:1 increment missing");

  // at 1:4 no increment happens off the prescaler terminal count
  chk_pre_four: assert property (@(posedge clk) disable iff (!nrst)
    preSel == 2'h1 && pre_r[1:0] != 2'h3 && !wrStb |=> $stable(count_r))
    else $error("1:4 prescale stepped early");

  // flag set follows the postscaler output
  chk_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    postOut |=> matchFlag)
    else $error("match flag not set");

  // flag stays set unless cleared by software
  chk_flag_keep: assert property (@(posedge clk) disable iff (!nrst)
    matchFlag && !wrFlag |=> matchFlag)
    else $error("match flag dropped");

  // period reads back as written
  chk_period_wr: assert property (@(posedge clk) disable iff (!nrst)
    wrPeriod |=> period_r == $past(wrData))
    else $error("period write lost");

  // after reset count is zero and period all ones
  chk_reset_val: assert property (@(posedge clk)
    !nrst |=> count_r == 8'h00 && period_r == 8'hff)
    else $error("reset values wrong");

  // reset clears control, both scalers, the flag and the read port
  chk_reset_ctl: assert property (@(posedge clk)
    !nrst |=> control_r == 7'h00 && pre_r == '0 && post_r == 4'h0 && !matchFlag
              && rdData == 8'h00)
    else $error("reset left state behind");

  // a software clear without a set drops the flag
  chk_flag_clear: assert property (@(posedge clk) disable iff (!nrst)
    wrFlag && !wrData[FLAG_BIT] && !postOut |=> !matchFlag)
    else $error("match flag not cleared");

  // writing one to the flag bit never sets it
  chk_flag_one: assert property (@(posedge clk) disable iff (!nrst)
    wrFlag && wrData[FLAG_BIT] && !matchFlag && !postOut |=> !matchFlag)
    else $error("software set the match flag");

  // the flag only rises after a postscaler output
  chk_flag_rise: assert property (@(posedge clk) disable iff (!nrst)
    $rose(matchFlag) |-> $past(postOut))
    else $error("match flag rose without output");

  // a clear flag stays clear without a postscaler output
  chk_flag_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !matchFlag && !postOut |=> !matchFlag)
    else $error("match flag set spuriously");

  // period changes only by a write
  chk_period_hold: assert property (@(posedge clk) disable iff (!nrst)
    !wrPeriod |=> $stable(period_r))
    else $error("period moved without write");

  // control takes the low seven bits of a write
  chk_ctl_write: assert property (@(posedge clk) disable iff (!nrst)
    wrControl |=> control_r == $past(wrData[6:0]))
    else $error("control write lost");

  // control changes only by a write
  chk_ctl_hold: assert property (@(posedge clk) disable iff (!nrst)
    !wrControl |=> $stable(control_r))
    else $error("control moved without write");

  // a stopped prescaler holds its value
  chk_pre_idle: assert property (@(posedge clk) disable iff (!nrst)
    !timerRun && !wrCount && !wrControl |=> $stable(pre_r))
    else $error("prescaler moved while stopped");

  // a running prescaler steps once per instruction clock
  chk_pre_step: assert property (@(posedge clk) disable iff (!nrst)
    timerRun && !wrCount && !wrControl |=> pre_r == $past(pre_r) + 1'b1)
    else $error("prescaler did not step");

  // the postscaler never passes the selected ratio
  chk_post_range: assert property (@(posedge clk) disable iff (!nrst)
    post_r <= postSel)
    else $error("postscaler out of range");

  // the postscaler moves only on a wrap or a clearing write
  chk_post_hold: assert property (@(posedge clk) disable iff (!nrst)
    !(incr && match) && !wrCount && !wrControl |=> $stable(post_r))
    else $error("postscaler moved without match");

  // a wrap below the ratio advances the postscaler
  chk_post_step: assert property (@(posedge clk) disable iff (!nrst)
    incr && match && post_r != postSel |=> post_r == $past(post_r) + 4'h1)
    else $error("postscaler did not advance");

  // a wrap at the ratio restarts the postscaler
  chk_post_wrap: assert property (@(posedge clk) disable iff (!nrst)
    incr && match && post_r == postSel |=> post_r == 4'h0)
    else $error("postscaler did not wrap");

  // a tick below the period advances the count
  chk_count_step: assert property (@(posedge clk) disable iff (!nrst)
    incr && !match |=> count_r == $past(count_r) + 8'h01)
    else $error("count did not advance");

  // no tick and no write leaves the count alone
  chk_count_hold: assert property (@(posedge clk) disable iff (!nrst)
    !incr && !wrCount |=> $stable(count_r))
    else $error("count moved without tick");

  // at 1:16 no increment off the terminal count
  chk_pre_sixteen: assert property (@(posedge clk) disable iff (!nrst)
    preSel == 2'h2 && pre_r[3:0] != 4'hf && !wrStb |=> $stable(count_r))
    else $error("1:16 prescale stepped early");

  // at 1:64 no increment off the terminal count
  chk_pre_sixtyfour: assert property (@(posedge clk) disable iff (!nrst)
    preSel == 2'h3 && pre_r[5:0] != 6'h3f && !wrStb |=> $stable(count_r))
    else $error("1:64 prescale stepped early");

  // 1:1 ticks every running cycle
  chk_div1_tick: assert property (@(posedge clk) disable iff (!nrst)
    preSel == 2'h0 && timerRun && !wrStb |-> incr)
    else $error("1:1 tick missing");

  // 1:4 ticks on its terminal count
  chk_div4_tick: assert property (@(posedge clk) disable iff (!nrst)
    preSel == 2'h1 && timerRun && pre_r[1:0] == 2'h3 && !wrStb |-> incr)
    else $error("1:4 tick missing");

  // 1:16 ticks on its terminal count
  chk_div16_tick: assert property (@(posedge clk) disable iff (!nrst)
    preSel == 2'h2 && timerRun && pre_r[3:0] == 4'hf && !wrStb |-> incr)
    else $error("1:16 tick missing");

  // 1:64 ticks on its terminal count
  chk_div64_tick: assert property (@(posedge clk) disable iff (!nrst)
    preSel == 2'h3 && timerRun && pre_r[5:0] == 6'h3f && !wrStb |-> incr)
    else $error("1:64 tick missing");

  // a stopped timer never produces a postscaler output
  chk_stop_quiet: assert property (@(posedge clk) disable iff (!nrst)
    !timerRun |-> !postOut)
    else $error("output while stopped");

  // read data is zero outside the cycle after a read strobe
  chk_rd_idle: assert property (@(posedge clk) disable iff (!nrst)
    !rdStb |=> rdData == 8'h00)
    else $error("read data outside read cycle");

  // count reads back its value at the strobe
  chk_rd_count: assert property (@(posedge clk) disable iff (!nrst)
    rdStb && addr == OFF_COUNT |=> rdData == $past(count_r))
    else $error("count read wrong");

  // period reads back its value at the strobe
  chk_rd_period: assert property (@(posedge clk) disable iff (!nrst)
    rdStb && addr == OFF_PERIOD |=> rdData == $past(period_r))
    else $error("period read wrong");

  // control reads back with bit 7 as zero
  chk_rd_ctl: assert property (@(posedge clk) disable iff (!nrst)
    rdStb && addr == OFF_CONTROL |=> rdData == {1'b0, $past(control_r)})
    else $error("control read wrong");

  // flag register shows only the match flag bit
  chk_rd_flag: assert property (@(posedge clk) disable iff (!nrst)
    rdStb && addr == OFF_FLAG |=> rdData == {6'h00, $past(flag_r), 1'b0})
    else $error("flag read wrong");
endmodule : pmt_timer
`default_nettype wire

// ---- test/pmt_timer_tb.sv ----
`timescale 1ns/100ps
`default_nettype none
module pmt_timer_tb;
  import pmt_pkg::*;
  logic       clk;
  logic       nrst;
  logic [1:0] addr;
  logic [7:0] wrData;
  logic       wrStb;
  logic       rdStb;
  logic [7:0] rdData;
  logic       matchFlag;
  logic       timerRun;
  int         errTotal;
  int         comparisons;
  logic [7:0] rv;

  pmt_timer pmt_timer_inst (.clk(clk), .nrst(nrst), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .matchFlag(matchFlag),
    .timerRun(timerRun));

  // 50 MHz clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task check(input string what, input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task wr(input logic [1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'b1;
    @(posedge clk);
    wrStb  <= 1'b0;
    #1;
  endtask : wr

  // read data only stands in the cycle after the strobe
  task rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr  <= a;
    rdStb <= 1'b1;
    @(posedge clk);
    rdStb <= 1'b0;
    #1 v = rdData;
  endtask : rd

  task test_reset;
    rd(OFF_COUNT, rv);
    check("count", rv, COUNT_RST);
    rd(OFF_PERIOD, rv);
    check("period", rv, PERIOD_RST);
    rd(OFF_CONTROL, rv);
    check("control", rv, {1'b0, CONTROL_RST});
    check("flag", {7'h0, matchFlag}, 8'h00);
    check("run", {7'h0, timerRun}, 8'h00);
  endtask : test_reset

  task test_regs;
    wr(OFF_PERIOD, 8'ha5);
    rd(OFF_PERIOD, rv);
    check("period", rv, 8'ha5);
    wr(OFF_COUNT, 8'h3c);
    rd(OFF_COUNT, rv);
    check("count", rv, 8'h3c);
    wr(OFF_CONTROL, 8'hf8);
    rd(OFF_CONTROL, rv);
    check("control", rv, 8'h78);
    rd(OFF_COUNT, rv);
    check("count kept", rv, 8'h3c);
  endtask : test_regs

  // flag delay is (post+1) wraps of div*(period+1) ticks, small slack for pipeline
  task run_case(input logic [1:0] pre, input logic [3:0] post, input logic [7:0] per);
    int n;
    int exp;
    logic [7:0] held;
    n = 0;
    exp = (int'(post) + 1) * (1 << (2 * pre)) * (int'(per) + 1);
    wr(OFF_PERIOD, per);
    wr(OFF_COUNT, 8'h00);
    wr(OFF_FLAG, 8'h00);
    check("flag clear", {7'h0, matchFlag}, 8'h00);
    wr(OFF_CONTROL, {1'b0, post, 1'b1, pre});
    check("run", {7'h0, timerRun}, 8'h01);
    while (matchFlag !== 1'b1 && n < 5000) begin
      @(posedge clk);
      #1 n++;
    end
    check("flag delay", {7'h0, 1'(n >= exp - 1 && n <= exp + 3)}, 8'h01);
    wr(OFF_CONTROL, {1'b0, post, 1'b0, pre});
    rd(OFF_COUNT, held);
    check("count bound", {7'h0, 1'(held <= per)}, 8'h01);
    repeat (4 << (2 * pre)) @(posedge clk);
    wr(OFF_CONTROL, {1'b0, ~post, 1'b0, pre});
    rd(OFF_COUNT, rv);
    check("count stopped", rv, held);
    check("flag sticky", {7'h0, matchFlag}, 8'h01);
    rd(OFF_FLAG, rv);
    check("flag reg", rv, 8'(1 << FLAG_BIT));
  endtask : run_case

  task test_midreset;
    wr(OFF_CONTROL, 8'h04);
    repeat (5) @(posedge clk);
    nrst <= 1'b0;
    @(posedge clk);
    @(posedge clk);
    nrst <= 1'b1;
    test_reset();
  endtask : test_midreset

  task finish_test;
    $display("comparisons %0d mismatches %0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : finish_test

  // main sequence: every prescale code, post extremes, period zero
  initial begin
    nrst = 1'b0;
    addr = 2'h0;
    wrData = 8'h00;
    wrStb = 1'b0;
    rdStb = 1'b0;
    errTotal = 0;
    comparisons = 0;
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    test_reset();
    test_regs();
    for (int p = 0; p < 4; p++) begin
      run_case(2'(p), 4'h1, 8'h03);
    end
    run_case(2'h0, 4'hf, 8'h00);
    run_case(2'h1, 4'h0, 8'h02);
    test_midreset();
    finish_test();
  end

  // watchdog well beyond the expected run length
  initial begin
    #400000;
    errTotal++;
    finish_test();
  end
endmodule : pmt_timer_tb
`default_nettype wire
